// File: design/lsou_defines.svh
// Constants of the load/store ordering unit.
`ifndef LSOU_DEFINES_SVH
`define LSOU_DEFINES_SVH
`define SB_DEPTH 4
`define SB_IDX_W 2
`define SB_CNT_W 3
`define ADDR_W 32
`define DATA_W 32
`define MT_W 2
`define MT_WRITE_BACK 2'h0
`define MT_OTHER 2'h1
`endif

// File: design/lsou_pkg.sv
// Types shared by the load/store ordering unit.
`include "lsou_defines.svh"
package lsou_pkg;
    typedef logic [`ADDR_W-1:0] addr_t;
    typedef logic [`DATA_W-1:0] data_t;
    typedef struct packed {
        logic valid;
        addr_t addr;
        data_t data;
        logic [`MT_W-1:0] mem_type;
        logic string_op;
    } mem_req_t;
    typedef struct packed {
        logic valid;
        addr_t addr;
        data_t data;
    } mem_wr_t;
    typedef enum logic [1:0] {
        ST_RUN = 2'h0,
        ST_BARRIER = 2'h1,
        ST_LOCKED = 2'h2
    } order_state_t;
endpackage

// File: design/sb_match.sv
// One store buffer entry address comparator.
`timescale 1ns/100ps
`default_nettype none
module sb_match
    import lsou_pkg::*;
(
    input wire logic valid_in,
    input wire addr_t entry_addr_in,
    input wire addr_t probe_addr_in,
    output logic hit_out
);
    // Natural alignment means word addresses either match or do not overlap.
    assign hit_out = valid_in && (entry_addr_in[`ADDR_W-1:2] == probe_addr_in[`ADDR_W-1:2]);
endmodule
`default_nettype wire

// File: design/load_store_ordering_unit.sv
// Store buffer and load/store ordering control of one core.
`timescale 1ns/100ps
`default_nettype none
module load_store_ordering_unit
    import lsou_pkg::*;
(
    input wire logic clock_in,
    input wire logic rstn_in,
    // Load issue from the pipeline, oldest pending load only.
    input wire mem_req_t load_req_in,
    output logic load_ready_out,
    output logic load_done_out,
    output logic load_fwd_out,
    output data_t load_data_out,
    // Retired store from the pipeline.
    input wire mem_req_t store_req_in,
    input wire logic store_retired_in,
    input wire logic older_loads_done_in,
    output logic store_ready_out,
    // Ordering instructions.
    input wire logic barrier_in,
    input wire logic locked_xchg_in,
    output logic order_busy_out,
    // Coherent memory system.
    output mem_wr_t mem_wr_out,
    input wire logic mem_wr_ack_in,
    output logic mem_rd_valid_out,
    output addr_t mem_rd_addr_out,
    input wire logic mem_rd_valid_in,
    input wire data_t mem_rd_data_in,
    output logic sb_empty_out
);
    // =========================================================
    // Store buffer storage
    // =========================================================
    addr_t sb_addr_q [`SB_DEPTH];
    data_t sb_data_q [`SB_DEPTH];
    logic [`SB_DEPTH-1:0] sb_valid_q;
    logic [`SB_IDX_W-1:0] head_q;
    logic [`SB_IDX_W-1:0] tail_q;
    logic [`SB_CNT_W-1:0] count_q;
    wire logic [`SB_DEPTH-1:0] hit;
    order_state_t state_q;
    logic rd_busy_q;
    addr_t rd_addr_q;
    logic wr_busy_q;
    logic push;
    logic pop;
    logic full;
    logic any_hit;
    logic [`SB_IDX_W-1:0] young_idx;
    logic load_go;
    logic load_ok_type;
    logic fwd_hit;
    logic rd_return;
    logic wr_start;
    logic xchg_seen_q;

    assign full = (count_q == `SB_CNT_W'(`SB_DEPTH));
    assign sb_empty_out = (count_q == `SB_CNT_W'h0);

    // A store enters only once retired and after every older load is done,
    // so nothing speculative or ahead of a load ever reaches memory.
    assign store_ready_out = !full && store_retired_in && older_loads_done_in;
    assign push = store_req_in.valid && store_ready_out;
    assign pop = wr_busy_q && mem_wr_ack_in;

    // =========================================================
    // Address match against every entry
    // =========================================================
    genvar g;
    generate
        for (g = 0; g < `SB_DEPTH; g++) begin : g_match
            sb_match u_match (
                .valid_in(sb_valid_q[g]),
                .entry_addr_in(sb_addr_q[g]),
                .probe_addr_in(load_req_in.addr),
                .hit_out(hit[g])
            );
        end
    endgenerate

    assign any_hit = |hit;

    // Youngest matching entry, searched from oldest toward tail.
    always_comb begin
        logic [`SB_IDX_W-1:0] idx;
        idx = head_q;
        young_idx = head_q;
        for (int i = 0; i < `SB_DEPTH; i++) begin
            idx = head_q + `SB_IDX_W'(i);
            if (hit[idx]) begin
                young_idx = idx;
            end
        end
    end

    // =========================================================
    // Ordering state
    // =========================================================
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q <= ST_RUN;
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (locked_xchg_in) begin
                        state_q <= ST_LOCKED;
                    end else if (barrier_in) begin
                        state_q <= ST_BARRIER;
                    end
                end
                ST_BARRIER: begin
                    if (sb_empty_out && !wr_busy_q) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_LOCKED: begin
                    // Hold until the exchange's own store has entered and drained.
                    if (xchg_seen_q && sb_empty_out && !wr_busy_q && !push) begin
                        state_q <= ST_RUN;
                    end
                end
                default: state_q <= ST_RUN;
            endcase
        end
    end

    assign order_busy_out = (state_q != ST_RUN);

    // The exchange's store may arrive in the pulse cycle or later; without this
    // flag an empty buffer would release younger loads before that store exists.
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            xchg_seen_q <= 1'b0;
        end else if (state_q == ST_RUN) begin
            xchg_seen_q <= locked_xchg_in && push;
        end else if (push) begin
            xchg_seen_q <= 1'b1;
        end
    end

    // Non write-back loads are kept strictly behind buffered stores.
    assign load_ok_type = (load_req_in.mem_type == `MT_WRITE_BACK) || sb_empty_out;
    // One load in flight keeps load-load order; string loads take the same path,
    // which is stronger than their exemption needs.
    assign load_ready_out = (state_q == ST_RUN) && !barrier_in && !locked_xchg_in
                            && !rd_busy_q && load_ok_type;
    assign load_go = load_req_in.valid && load_ready_out;
    // A forwarded load completes at once; a read completes on the memory's answer.
    assign fwd_hit = load_go && any_hit;
    assign rd_return = rd_busy_q && mem_rd_valid_in;

    // =========================================================
    // Store buffer fill and drain
    // =========================================================
    // Payload is written only on a push and cleared only by reset; the valid bits
    // alone decide what a load probe may match.
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < `SB_DEPTH; i++) begin
                sb_addr_q[i] <= '0;
                sb_data_q[i] <= '0;
            end
        end else if (push) begin
            sb_addr_q[tail_q] <= store_req_in.addr;
            sb_data_q[tail_q] <= store_req_in.data;
        end
    end

    // An entry stays valid until its store is acknowledged, so loads can still
    // forward from it while it is on its way to memory.
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sb_valid_q <= '0;
        end else begin
            if (push) begin
                sb_valid_q[tail_q] <= 1'b1;
            end
            if (pop) begin
                sb_valid_q[head_q] <= 1'b0;
            end
        end
    end

    // Entries enter at the tail and leave only at the head, so memory sees
    // them in the order in which the pipeline retired them.
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tail_q <= '0;
            head_q <= '0;
        end else begin
            if (push) begin
                tail_q <= tail_q + `SB_IDX_W'h1;
            end
            if (pop) begin
                head_q <= head_q + `SB_IDX_W'h1;
            end
        end
    end

    // The count carries one bit more than the pointers, because equal pointers
    // alone cannot tell a full buffer from an empty one.
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            count_q <= '0;
        end else if (push && !pop) begin
            count_q <= count_q + `SB_CNT_W'h1;
        end else if (pop && !push) begin
            count_q <= count_q - `SB_CNT_W'h1;
        end
    end

    // Only the oldest entry is ever offered, one at a time, and it leaves the
    // buffer only on the memory's acknowledge of global visibility; the
    // coherent memory then serialises it against other cores' stores.
    assign wr_start = !wr_busy_q && sb_valid_q[head_q];

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wr_busy_q <= 1'b0;
        end else if (pop) begin
            wr_busy_q <= 1'b0;
        end else if (wr_start) begin
            wr_busy_q <= 1'b1;
        end
    end

    // The offered store is frozen until acknowledged and then dropped for at
    // least one cycle, so the memory never takes the same entry twice.
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mem_wr_out <= '0;
        end else if (pop) begin
            mem_wr_out <= '0;
        end else if (wr_start) begin
            mem_wr_out.valid <= 1'b1;
            mem_wr_out.addr <= sb_addr_q[head_q];
            mem_wr_out.data <= sb_data_q[head_q];
        end
    end

    // =========================================================
    // Load service
    // =========================================================
    // At most one read is outstanding; this is what keeps load-load order.
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rd_busy_q <= 1'b0;
            rd_addr_q <= '0;
        end else if (load_go && !any_hit) begin
            rd_busy_q <= 1'b1;
            rd_addr_q <= load_req_in.addr;
        end else if (rd_return) begin
            rd_busy_q <= 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            load_done_out <= 1'b0;
            load_fwd_out <= 1'b0;
        end else begin
            load_done_out <= fwd_hit || rd_return;
            load_fwd_out <= fwd_hit;
        end
    end

    // The result stands until the next completion, for a consumer that is slow.
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            load_data_out <= '0;
        end else if (fwd_hit) begin
            // Forward the youngest older store to the same word.
            load_data_out <= sb_data_q[young_idx];
        end else if (rd_return) begin
            load_data_out <= mem_rd_data_in;
        end
    end

    assign mem_rd_valid_out = rd_busy_q;
    assign mem_rd_addr_out = rd_addr_q;
endmodule
`default_nettype wire

// File: testbench/lsou_checker.sv
// Port checks for the load/store ordering unit.
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Checker
module lsou_checker
    import lsou_pkg::*;
(
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic load_ready_out,
    input wire logic load_done_out,
    input wire logic load_fwd_out,
    input wire logic store_retired_in,
    input wire logic older_loads_done_in,
    input wire logic store_ready_out,
    input wire logic order_busy_out,
    input wire mem_wr_t mem_wr_out,
    input wire logic mem_wr_ack_in,
    input wire logic mem_rd_valid_out,
    input wire addr_t mem_rd_addr_out,
    input wire logic mem_rd_valid_in,
    input wire logic sb_empty_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    sequence wr_wait;
        mem_wr_out.valid && !mem_wr_ack_in;
    endsequence
    sequence rd_done;
        mem_rd_valid_out && mem_rd_valid_in;
    endsequence
    AST_WR_HOLD: assert property (wr_wait |=> $stable(mem_wr_out))
        else $error("store changed before ack");
    AST_WR_GAP: assert property (mem_wr_out.valid && mem_wr_ack_in |=> !mem_wr_out.valid)
        else $error("store not dropped after ack");
    AST_RD_HOLD: assert property (mem_rd_valid_out && !mem_rd_valid_in
        |=> mem_rd_valid_out && $stable(mem_rd_addr_out)) else $error("read changed");
    AST_RD_DONE: assert property (rd_done |=> load_done_out && !load_fwd_out)
        else $error("load result missing");
    AST_ONE_LOAD: assert property (mem_rd_valid_out |-> !load_ready_out)
        else $error("load taken while read open");
    AST_FENCE: assert property (order_busy_out |-> !load_ready_out)
        else $error("load taken during barrier");
    AST_DRAIN: assert property ($fell(order_busy_out) |-> $past(sb_empty_out))
        else $error("barrier ended with stores left");
    AST_RETIRE: assert property (!(store_retired_in && older_loads_done_in)
        |-> !store_ready_out) else $error("unretired store accepted");
endmodule
bind load_store_ordering_unit lsou_checker chk_u (.*);
`default_nettype wire

// File: testbench/mem_model.sv
// Coherent memory model that answers after a set latency.
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Memory model
module mem_model
    import lsou_pkg::*;
(
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic [4:0] lat_in,
    input wire mem_wr_t wr_in,
    input wire logic rd_in,
    input wire addr_t rd_addr_in,
    output logic ack_out,
    output logic rd_valid_out,
    output data_t rd_data_out
);
    data_t mem_q [16];
    logic [4:0] wc_q;
    logic [4:0] rc_q;
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wc_q <= 5'h00;
            ack_out <= 1'b0;
            for (int i = 0; i < 16; i++)
                mem_q[i] <= 32'hA0 + i;
        end else begin
            ack_out <= 1'b0;
            if (wr_in.valid && !ack_out) begin
                wc_q <= (wc_q >= lat_in) ? 5'h00 : wc_q + 5'h01;
                if (wc_q >= lat_in) begin
                    ack_out <= 1'b1;
                    mem_q[wr_in.addr[5:2]] <= wr_in.data;
                end
            end
        end
    end
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rc_q <= 5'h00;
            rd_valid_out <= 1'b0;
            rd_data_out <= 32'h0;
        end else begin
            rd_valid_out <= 1'b0;
            // Idle data toggles so a stale word never looks valid.
            rd_data_out <= ~rd_data_out;
            if (rd_in && !rd_valid_out) begin
                rc_q <= (rc_q >= lat_in) ? 5'h00 : rc_q + 5'h01;
                if (rc_q >= lat_in) begin
                    rd_valid_out <= 1'b1;
                    rd_data_out <= mem_q[rd_addr_in[5:2]];
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench of the load/store ordering unit.
`timescale 1ns/100ps
`default_nettype none
`include "lsou_defines.svh"
// ==========================================
// Bench
module tb_top
    import lsou_pkg::*;
;
    typedef struct packed {addr_t sa; data_t sd; addr_t la; logic so; logic fw;} row_t;
    localparam row_t ROWS [4] = '{'{32'h10, 32'h11, 32'h10, 1'b0, 1'b1},
        '{32'h20, 32'h22, 32'h24, 1'b0, 1'b0}, '{32'h2C, 32'h33, 32'h28, 1'b1, 1'b0},
        '{32'h10, 32'h44, 32'h10, 1'b0, 1'b1}};
    logic clock_in = 1'b0;
    logic rstn_in = 1'b0;
    mem_req_t ld = '0;
    mem_req_t st = '0;
    logic ret = 1'b1, old = 1'b1, bar = 1'b0, lx = 1'b0;
    logic [4:0] lat = 5'h06;
    logic ld_rdy, done, fwd, st_rdy, busy, rdv, rdvi, ack, empty;
    data_t ld_data, rd_data, shadow [16];
    addr_t rd_addr, pushed [$], seen [$];
    mem_wr_t wr;
    int err_count = 0;
    int n_checks = 0;
    load_store_ordering_unit dut_u (.clock_in(clock_in), .rstn_in(rstn_in),
        .load_req_in(ld), .load_ready_out(ld_rdy), .load_done_out(done),
        .load_fwd_out(fwd), .load_data_out(ld_data), .store_req_in(st),
        .store_retired_in(ret), .older_loads_done_in(old), .store_ready_out(st_rdy),
        .barrier_in(bar), .locked_xchg_in(lx), .order_busy_out(busy), .mem_wr_out(wr),
        .mem_wr_ack_in(ack), .mem_rd_valid_out(rdv), .mem_rd_addr_out(rd_addr),
        .mem_rd_valid_in(rdvi), .mem_rd_data_in(rd_data), .sb_empty_out(empty));
    mem_model mem_u (.clock_in(clock_in), .rstn_in(rstn_in), .lat_in(lat), .wr_in(wr),
        .rd_in(rdv), .rd_addr_in(rd_addr), .ack_out(ack), .rd_valid_out(rdvi),
        .rd_data_out(rd_data));
    initial forever #25 clock_in = ~clock_in;
    always @(posedge clock_in)
        if (wr.valid && ack)
            seen.push_back(wr.addr);
    task automatic chk(input string what, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s exp %h seen %h", what, e, s);
        end
    endtask
    task automatic stop_test();
        if (err_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic wait_for(input int w);
        int i;
        i = 0;
        #1;
        while (((w == 0) ? ld_rdy : (w == 1) ? st_rdy : done) !== 1'b1 && i < 300) begin
            @(posedge clock_in);
            #1;
            i++;
        end
        if (i == 300) begin
            err_count++;
            stop_test();
        end
    endtask
    task automatic store(input addr_t a, input data_t d);
        @(posedge clock_in);
        st <= '{1'b1, a, d, `MT_WRITE_BACK, 1'b0};
        shadow[a[5:2]] = d;
        pushed.push_back(a);
        wait_for(1);
        @(posedge clock_in);
        st.valid <= 1'b0;
    endtask
    task automatic load(input addr_t a, input logic [1:0] mt, input logic s, input logic f);
        @(posedge clock_in);
        ld <= '{1'b1, a, 32'h0, mt, s};
        wait_for(0);
        @(posedge clock_in);
        ld.valid <= 1'b0;
        wait_for(2);
        chk("load data", ld_data, shadow[a[5:2]]);
        chk("forward", fwd, f);
    endtask
    initial begin
        for (int i = 0; i < 16; i++)
            shadow[i] = 32'hA0 + i;
        repeat (8) @(posedge clock_in);
        rstn_in <= 1'b1;
        #1;
        chk("empty", empty, 1'b1);
        for (int r = 0; r < 4; r++) begin
            store(ROWS[r].sa, ROWS[r].sd);
            load(ROWS[r].la, `MT_WRITE_BACK, ROWS[r].so, ROWS[r].fw);
        end
        lat <= 5'h1E;
        for (int i = 0; i < 4; i++)
            store(4 * i, 32'hB0 + i);
        #1;
        chk("store ready", st_rdy, 1'b0);
        @(posedge clock_in);
        lat <= 5'h0A;
        bar <= 1'b1;
        @(posedge clock_in);
        bar <= 1'b0;
        #1;
        chk("busy", busy, 1'b1);
        load(32'h0, `MT_WRITE_BACK, 1'b0, 1'b0);
        chk("drained", empty, 1'b1);
        @(posedge clock_in);
        lx <= 1'b1;
        fork
            begin
                // The exchange's store comes late; younger loads must wait for it.
                repeat (2) @(posedge clock_in);
                store(32'h14, 32'h55);
            end
            begin
                @(posedge clock_in);
                lx <= 1'b0;
            end
        join
        load(32'h14, `MT_WRITE_BACK, 1'b0, 1'b0);
        chk("drained", empty, 1'b1);
        @(posedge clock_in);
        ret <= 1'b0;
        #1;
        chk("store ready", st_rdy, 1'b0);
        @(posedge clock_in);
        ret <= 1'b1;
        old <= 1'b0;
        #1;
        chk("store ready", st_rdy, 1'b0);
        @(posedge clock_in);
        old <= 1'b1;
        store(32'h18, 32'h66);
        load(32'h18, `MT_OTHER, 1'b0, 1'b0);
        chk("drained", empty, 1'b1);
        chk("stores", seen.size(), pushed.size());
        foreach (pushed[i])
            chk("store order", seen[i], pushed[i]);
        stop_test();
    end
endmodule
`default_nettype wire
